//--- apms_pkg.sv
// Shared constants for the power-mode sequencer link ends.
// Assumes both ends compile this package first.
package apms_pkg;
  // ----------------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    APMS_NORMAL,
    APMS_PARTIAL,
    APMS_FULL
  } apms_mode_t;

  // ----------------------------------------------------------------------
  // Frame edge counts
  // ----------------------------------------------------------------------
  localparam logic [4:0] EDGE_GLITCH = 5'h02;
  localparam logic [4:0] EDGE_KEEP = 5'h0a;
  localparam logic [4:0] EDGE_HOLD_LAST = 5'h0d;
  localparam logic [4:0] EDGE_FRAME = 5'h10;
  localparam logic [4:0] EDGE_SHORT = 5'h05;

  // ----------------------------------------------------------------------
  // Host timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int SCLK_DIV = 8;
  localparam int QUIET_NS = 30;
  localparam int QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_US = 650;
  localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
endpackage

//--- apms_if.sv
// Link between host serial master and converter power sequencer.
// Assumes the bench resolves serial_out from its enable.
`timescale 1ns/1ps
interface apms_if;
  logic sel_n;
  logic sclk;
  logic serial_out;
  logic serial_out_oe;
  modport dev (
    input sel_n,
    input sclk,
    output serial_out,
    output serial_out_oe
  );
  modport host (
    output sel_n,
    output sclk,
    input serial_out,
    input serial_out_oe
  );
endinterface

//--- apms_dev.sv
// Converter end: power-mode sequencing on the serial clock.
// Assumes sclk idles high and select is glitch-free to the link clock.
//
// Operation
// - One dummy cycle wakes partial power-down
// - Host waits idle gap after wake
// - Wake from power-down tracks on first edge
// - Short wake cycle allowed after ten edges
// - Early release enters partial power-down
// - Early release from partial gives full
// - One falling edge after release sets the mode
// - Full wake needs select past tenth edge
// - Host waits wake delay after full; host waits only the quiet gap if released before the sixteenth edge (quiet gap restarts while data enable is high)
// - Wake delay is 650 us
// - Supply-on mode may be any mode
// - Two dummy cycles reach partial
// - Three dummy cycles reach full
// - Track mode right after supply-on
// - Host allows acquisition after dummy cycle
// - Release before second edge is glitch
// - Ten edges keep the converter powered
// - Glitch in partial stays partial
// - Output floats at sixteenth edge or at first falling edge after release
`timescale 1ns/1ps
module apms_dev (
  apms_if.dev lnk, // Link to host
  input wire logic rst, // Power-on reset, sync to sclk
  input wire logic [1:0] init_mode, // Supply-on mode strap
  output logic [1:0] mode, // Power mode, delayed one falling sclk edge
  output logic tracking, // Track-and-hold in track
  output logic converting // Frame in progress
);
  apms_pkg::apms_mode_t mode_r;
  logic [4:0] edge_r;
  logic sel_d_r;
  logic powered_down;
  logic frame_on;
  logic [1:0] mode_nxt;

  // ----------------------------------------------------------------------
  // Frame edge count on falling sclk
  // ----------------------------------------------------------------------
  // Select is sampled on falling sclk; release is seen at the next edge,
  // so the count is held until that edge, which clears it to zero.
  always_ff @(negedge lnk.sclk) begin
    if (rst) begin
      edge_r <= 5'h00;
      sel_d_r <= 1'b1;
    end else begin
      sel_d_r <= lnk.sel_n;
      if (lnk.sel_n) begin
        edge_r <= 5'h00;
      end else if (edge_r != apms_pkg::EDGE_FRAME) begin
        edge_r <= edge_r + 5'h01;
      end
    end
  end

  assign frame_on = !lnk.sel_n;
  assign powered_down = (mode_r != apms_pkg::APMS_NORMAL);

  // ----------------------------------------------------------------------
  // Mode decision at release
  // ----------------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    if (edge_r < apms_pkg::EDGE_GLITCH) begin
      mode_nxt = mode_r;
    end else if (edge_r < apms_pkg::EDGE_KEEP) begin
      if (mode_r == apms_pkg::APMS_NORMAL) begin
        mode_nxt = apms_pkg::APMS_PARTIAL;
      end else begin
        mode_nxt = apms_pkg::APMS_FULL;
      end
    end else begin
      mode_nxt = apms_pkg::APMS_NORMAL;
    end
  end

  // Release needs one further falling clock: decided on the first edge that sees
  // select high, which the host gives before the next frame.
  always_ff @(negedge lnk.sclk) begin
    if (rst) begin
      mode_r <= apms_pkg::apms_mode_t'(init_mode);
    end else if (lnk.sel_n && !sel_d_r) begin
      mode_r <= apms_pkg::apms_mode_t'(mode_nxt);
    end
  end

  // ----------------------------------------------------------------------
  // Track-and-hold and serial output
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.sclk) begin
    if (rst) begin
      tracking <= 1'b1;
    end else if (lnk.sel_n) begin
      tracking <= 1'b1;
    end else if (powered_down && edge_r != 5'h00) begin
      tracking <= 1'b1;
    end else if (edge_r >= apms_pkg::EDGE_HOLD_LAST) begin
      tracking <= 1'b1;
    end else begin
      tracking <= powered_down ? tracking : 1'b0;
    end
  end

  always_ff @(negedge lnk.sclk) begin
    if (rst) begin
      lnk.serial_out_oe <= 1'b0;
      lnk.serial_out <= 1'b0;
    end else begin
      lnk.serial_out <= 1'b0;
      lnk.serial_out_oe <= frame_on &&
        (edge_r + 5'h01 < apms_pkg::EDGE_FRAME);
    end
  end

  always_ff @(negedge lnk.sclk) begin
    if (rst) begin
      mode <= 2'h0;
      converting <= 1'b0;
    end else begin
      mode <= mode_r;
      converting <= frame_on;
    end
  end
endmodule

//--- apms_host.sv
// Host end: serial master issuing frames of chosen length.
// Assumes cmd_valid comes from logic on clk.
`timescale 1ns/1ps
module apms_host #(
  parameter int WAKE_CYC = apms_pkg::WAKE_CYC // Full wake delay count
) (
  input wire logic clk, // System clock
  input wire logic rst, // Sync reset, active high
  apms_if.host lnk, // Link to converter
  input wire logic cmd_valid, // Start a frame
  input wire logic [4:0] cmd_edges, // Falling edges before release
  input wire logic cmd_wake_full, // Wait full wake delay after the frame, unless released before the sixteenth edge
  output logic cmd_ready, // Idle, can take a frame
  output logic done // Frame finished, one cycle
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_GAP} apms_hst_t;
  apms_hst_t st_r;
  logic [3:0] div_r;
  logic [4:0] cnt_r;
  logic [4:0] tgt_r;
  logic [31:0] gap_r;
  logic full_r;
  logic out_s1_r;
  logic out_s2_r;

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    out_s1_r <= lnk.serial_out_oe;
    out_s2_r <= out_s1_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      lnk.sel_n <= 1'b1;
      lnk.sclk <= 1'b1;
      div_r <= 4'h0;
      cnt_r <= 5'h00;
      tgt_r <= 5'h00;
      gap_r <= 32'h0000_0000;
      full_r <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (st_r)
        ST_IDLE: begin
          cmd_ready <= 1'b1;
          lnk.sclk <= 1'b1;
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            tgt_r <= cmd_edges;
            full_r <= cmd_wake_full;
            lnk.sel_n <= 1'b0;
            cnt_r <= 5'h00;
            div_r <= 4'h0;
            st_r <= ST_LOW;
          end
        end
        ST_LOW: begin
          // Clock runs one extra falling edge after release so the
          // converter sees select high. Release sits mid low phase,
          // never on an sclk edge, so the edge count cannot race it.
          div_r <= div_r + 4'h1;
          if (div_r == 4'(apms_pkg::SCLK_DIV / 2 - 1)) begin
            div_r <= 4'h0;
            lnk.sclk <= !lnk.sclk;
            if (lnk.sclk) begin
              if (cnt_r == tgt_r) begin
                st_r <= ST_GAP;
                gap_r <= full_r ? 32'(WAKE_CYC) :
                  32'(apms_pkg::QUIET_CYC);
              end else begin
                cnt_r <= cnt_r + 5'h01;
              end
            end
          end else if (!lnk.sclk && div_r == 4'h1 && cnt_r == tgt_r) begin
            lnk.sel_n <= 1'b1;
          end
        end
        ST_GAP: begin
          lnk.sclk <= 1'b1;
          lnk.sel_n <= 1'b1;
          if (out_s2_r) begin
            gap_r <= 32'(apms_pkg::QUIET_CYC);
          end else if (gap_r != 32'h0000_0000) begin
            gap_r <= gap_r - 32'h0000_0001;
          end else begin
            done <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- apms_asserts.sv
// Checks on the link between host master and converter end.
// Assumes the bench instantiates it beside the interface.
`timescale 1ns/1ps
module apms_asserts (
  input wire logic clk, // Host clock
  input wire logic rst, // Host reset
  input wire logic dev_rst, // Converter reset
  input wire logic sel_n, // Select, active low
  input wire logic sclk, // Serial clock
  input wire logic serial_out, // Serial data
  input wire logic serial_out_oe // Data enable
);
  // --------------------------------------------------------------
  // Edge counter
  // --------------------------------------------------------------
  logic sclk_r;
  logic [4:0] cnt_r;
  always_ff @(posedge clk) begin
    sclk_r <= sclk;
  end
  // Saturates so a long frame cannot wrap back below sixteen
  always_ff @(posedge clk) begin
    if (sel_n) begin
      cnt_r <= 5'h00;
    end else if (sclk_r && !sclk && cnt_r != apms_pkg::EDGE_FRAME) begin
      cnt_r <= cnt_r + 5'h01;
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || dev_rst);
  sequence s_release;
    $rose(sel_n);
  endsequence
  sequence s_idle;
    sel_n[*8] ##1 sel_n[*5];
  endsequence
  oe_release_a: assert property (s_release |-> ##[0:10] !serial_out_oe)
    else $error("data enable still high after select release");
  oe_idle_a: assert property (s_idle |-> !serial_out_oe)
    else $error("data enable high while idle");
  oe_sixteen_a: assert property (
    cnt_r == apms_pkg::EDGE_FRAME |-> ##[0:2] !serial_out_oe)
    else $error("data enable high past sixteenth edge");
  oe_start_a: assert property ($fell(sel_n) |-> ##[0:12] serial_out_oe)
    else $error("data enable not raised in frame");
  sclk_idle_a: assert property (s_idle |-> sclk)
    else $error("serial clock not idle high");
  quiet_gap_a: assert property (s_release |-> sel_n[*8])
    else $error("select lowered inside idle gap");
  sclk_pace_a: assert property (
    !sel_n && $changed(sclk) |=> $stable(sclk)[*3])
    else $error("serial clock half period too short");
  start_high_a: assert property ($fell(sel_n) |-> sclk)
    else $error("frame started with serial clock low");
endmodule

//--- adc_power_mode_sequencer_test.sv
// Bench: host end drives the converter end through the link.
// Assumes package, interface, both ends and checker compiled first.
`timescale 1ns/1ps
module adc_power_mode_sequencer_test;
  logic clk, rst, dev_rst, cmd_valid, cmd_wake_full, cmd_ready, done;
  logic tracking, converting;
  logic [4:0] cmd_edges;
  logic [1:0] init_mode, mode;
  int err_total, tests_run;
  logic [4:0] edges_q [8] = '{5'h10, 5'h01, 5'h02, 5'h01, 5'h09, 5'h0c,
    5'h0a, 5'h10};
  logic full_q [8] = '{0, 0, 0, 0, 0, 1, 0, 0};
  // Mode output lags one frame, so each entry is the previous result
  apms_pkg::apms_mode_t exp_q [8] = '{apms_pkg::APMS_PARTIAL,
    apms_pkg::APMS_NORMAL, apms_pkg::APMS_NORMAL, apms_pkg::APMS_PARTIAL,
    apms_pkg::APMS_PARTIAL, apms_pkg::APMS_FULL, apms_pkg::APMS_NORMAL,
    apms_pkg::APMS_NORMAL};
  apms_if lnk();
  apms_dev u_apms_dev(.lnk(lnk), .rst(dev_rst), .init_mode(init_mode),
    .mode(mode), .tracking(tracking), .converting(converting));
  apms_host #(.WAKE_CYC(50)) u_apms_host(.clk(clk), .rst(rst), .lnk(lnk),
    .cmd_valid(cmd_valid), .cmd_edges(cmd_edges),
    .cmd_wake_full(cmd_wake_full), .cmd_ready(cmd_ready), .done(done));
  apms_asserts u_apms_asserts(.clk(clk), .rst(rst), .dev_rst(dev_rst),
    .sel_n(lnk.sel_n), .sclk(lnk.sclk), .serial_out(lnk.serial_out),
    .serial_out_oe(lnk.serial_out_oe));
  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic frame(input logic [4:0] edges, input logic full);
    int n;
    while (cmd_ready !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b1;
    cmd_edges = edges;
    cmd_wake_full = full;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) begin
      err_total++;
    end
    #1;
  endtask
  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #80000;
    err_total++;
    end_sim();
  end
  initial begin
    err_total = 0;
    tests_run = 0;
    rst = 1'b1;
    dev_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_edges = 5'h10;
    cmd_wake_full = 1'b0;
    init_mode = 2'(apms_pkg::APMS_PARTIAL);
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    // Converter reset needs falling serial clock edges to land
    frame(5'h10, 1'b0);
    dev_rst = 1'b0;
    check(5'(tracking), 5'h01);
    for (int i = 0; i < 8; i++) begin
      frame(edges_q[i], full_q[i]);
      check(5'(mode), 5'(exp_q[i]));
      check(5'(converting), 5'h00);
    end
    end_sim();
  end
endmodule
